// ---- common/l1ss_pkg.sv ----
`default_nettype none
`include "l1ss_regs.svh"

package l1ss_pkg;

  // ------------------------------------------------------------
  // link and function power states
  // ------------------------------------------------------------
  // first members are the reset states, so an all-zero state word is legal
  typedef enum logic [2:0] {LK_L3, LK_L0, LK_L0S, LK_L1, LK_L2L3} link_state_e;
  typedef enum logic [2:0] {REQ_NONE, REQ_L0, REQ_L0S, REQ_L1, REQ_L2L3, REQ_L3} link_req_e;
  typedef enum logic [2:0] {D3_COLD, D0, D1, D2, D3_HOT} d_state_e;

  typedef struct packed {
    link_state_e [`L1SS_NPORT-1:0] lstate;
    logic [`L1SS_NPORT-1:0] l11;
    logic [`L1SS_NPORT-1:0] wait_lock;
    d_state_e [`L1SS_NPORT-1:0] dst;
    logic func_rst_n;
    logic pll_pd;
    logic [`L1SS_NPORT-1:0] rx_buf_pd;
    logic [`L1SS_NPORT-1:0] resume;
  } pm_state_s;

endpackage
`default_nettype wire

// ---- common/l1ss_regs.svh ----
`ifndef L1SS_REGS_SVH
`define L1SS_REGS_SVH

// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define L1SS_NPORT 3
`define L1SS_RST_STATE '0

`endif

// ---- rtl/link_l1_substate_power_control.sv ----
// Functional notes
// - clkreq asserted in L1 enters L1.1
// - in L1.1 receiver buffer off, PLL off requested
// - clkreq released returns L1.1 to L1, circuits on
// - shared PLL off only if all ports L1.1
// - functions held in reset while PERST# asserted
// - link states L0, L0s, L1, L2/L3, L3
// - function states D0, D1, D2, D3hot, D3cold
`timescale 1ns/1ps
`default_nettype none
`include "l1ss_regs.svh"

module link_l1_substate_power_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic perst_n,
  input wire logic [`L1SS_NPORT-1:0] clkreq_n,
  input wire logic [`L1SS_NPORT-1:0] l11_allow,
  input wire logic pll_lock,
  input wire l1ss_pkg::link_req_e [`L1SS_NPORT-1:0] link_req,
  input wire l1ss_pkg::d_state_e [`L1SS_NPORT-1:0] d_req,
  output logic func_rst_n,
  output logic pll_pd,
  output logic [`L1SS_NPORT-1:0] rx_buf_pd,
  output logic [`L1SS_NPORT-1:0] l11_active,
  output logic [`L1SS_NPORT-1:0] link_resume,
  output var l1ss_pkg::link_state_e [`L1SS_NPORT-1:0] link_state,
  output var l1ss_pkg::d_state_e [`L1SS_NPORT-1:0] d_state
);
  import l1ss_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pm_state_s st;
  pm_state_s next_st;

  function automatic logic d_legal(input d_state_e cur, input d_state_e req);
    logic ok;
    ok = 1'b0;
    unique case (cur)
      D0: ok = (req == D1) || (req == D2) || (req == D3_HOT);
      D1: ok = (req == D0) || (req == D2) || (req == D3_HOT);
      D2: ok = (req == D0) || (req == D3_HOT);
      D3_HOT: ok = (req == D0);
      D3_COLD: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (!perst_n) begin
      next_st = `L1SS_RST_STATE;
    end else begin
      next_st.func_rst_n = 1'b1;
      for (int p = 0; p < `L1SS_NPORT; p++) begin
        if (st.dst[p] == D3_COLD) begin
          next_st.dst[p] = D0;
        end else if (d_legal(st.dst[p], d_req[p])) begin
          next_st.dst[p] = d_req[p];
        end
        if (st.l11[p]) begin
          // clkreq_n high means the partner wants the clock back
          if (clkreq_n[p]) begin
            next_st.l11[p] = 1'b0;
            next_st.wait_lock[p] = 1'b1;
          end
        end else if (st.wait_lock[p]) begin
          // the pll may still be relocking after a global power-down
          if (pll_lock && !st.pll_pd) begin
            next_st.wait_lock[p] = 1'b0;
          end
        end else begin
          unique case (st.lstate[p])
            LK_L0: begin
              if (link_req[p] == REQ_L0S) begin
                next_st.lstate[p] = LK_L0S;
              end else if (link_req[p] == REQ_L1) begin
                next_st.lstate[p] = LK_L1;
              end else if (link_req[p] == REQ_L2L3) begin
                next_st.lstate[p] = LK_L2L3;
              end
            end
            LK_L0S: begin
              if (link_req[p] == REQ_L0) begin
                next_st.lstate[p] = LK_L0;
              end
            end
            LK_L1: begin
              // ports without substate support stay in plain L1
              if (!clkreq_n[p] && l11_allow[p]) begin
                next_st.l11[p] = 1'b1;
              end else if (link_req[p] == REQ_L0) begin
                next_st.lstate[p] = LK_L0;
              end
            end
            LK_L2L3: begin
              if (link_req[p] == REQ_L3) begin
                next_st.lstate[p] = LK_L3;
              end else if (link_req[p] == REQ_L0) begin
                next_st.lstate[p] = LK_L0;
              end
            end
            LK_L3: begin
              if (link_req[p] == REQ_L0) begin
                next_st.lstate[p] = LK_L0;
              end
            end
          endcase
        end
      end
      next_st.rx_buf_pd = next_st.l11;
      next_st.pll_pd = &next_st.l11;
      next_st.resume = ~(next_st.l11 | next_st.wait_lock);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= `L1SS_RST_STATE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign func_rst_n = st.func_rst_n;
  assign pll_pd = st.pll_pd;
  assign rx_buf_pd = st.rx_buf_pd;
  assign l11_active = st.l11;
  assign link_resume = st.resume;
  assign link_state = st.lstate;
  assign d_state = st.dst;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_perst_hold;
    @(posedge clk) disable iff (!rst_n)
    clk_en && !perst_n |=> !func_rst_n && (link_resume == '0) && !pll_pd;
  endproperty
  a_perst_hold: assert property (p_perst_hold) else $error("reset not held under perst");

  property p_pll_all;
    @(posedge clk) disable iff (!rst_n)
    pll_pd |-> (&l11_active) && (&rx_buf_pd);
  endproperty
  a_pll_all: assert property (p_pll_all) else $error("pll off while a port is out of l1.1");

  for (genvar g = 0; g < `L1SS_NPORT; g++) begin : g_chk
    sequence s_l1_clkreq;
      clk_en && perst_n && (link_state[g] == LK_L1) && !l11_active[g] && !st.wait_lock[g]
        && !clkreq_n[g] && l11_allow[g];
    endsequence
    sequence s_l11_release;
      clk_en && perst_n && l11_active[g] && clkreq_n[g];
    endsequence

    property p_l11_entry;
      @(posedge clk) disable iff (!rst_n)
      s_l1_clkreq |=> l11_active[g] && rx_buf_pd[g] && !link_resume[g];
    endproperty
    a_l11_entry: assert property (p_l11_entry) else $error("l1.1 not entered");

    property p_buf_off;
      @(posedge clk) disable iff (!rst_n)
      rx_buf_pd[g] |-> (link_state[g] == LK_L1) && l11_active[g];
    endproperty
    a_buf_off: assert property (p_buf_off) else $error("rx buffer off outside l1.1");

    property p_l11_exit;
      @(posedge clk) disable iff (!rst_n)
      s_l11_release |=> !l11_active[g] && !rx_buf_pd[g] && !pll_pd && (link_state[g] == LK_L1);
    endproperty
    a_l11_exit: assert property (p_l11_exit) else $error("l1.1 exit missed");

    property p_no_l11_disallowed;
      @(posedge clk) disable iff (!rst_n)
      clk_en && !l11_allow[g] && !l11_active[g] |=> !l11_active[g];
    endproperty
    a_no_l11_disallowed: assert property (p_no_l11_disallowed) else $error("l1.1 without support");

    property p_lock_wait;
      @(posedge clk) disable iff (!rst_n)
      s_l11_release ##1 (!pll_lock [*2]) |-> !link_resume[g];
    endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("resumed before pll lock");

    property p_l0s_entry;
      @(posedge clk) disable iff (!rst_n)
      clk_en && perst_n && (link_state[g] == LK_L0) && (link_req[g] == REQ_L0S)
        |=> (link_state[g] == LK_L0S);
    endproperty
    a_l0s_entry: assert property (p_l0s_entry) else $error("l0s not entered");

    property p_d3hot_exit;
      @(posedge clk) disable iff (!rst_n)
      clk_en && perst_n && (d_state[g] == D3_HOT) && (d_req[g] != D0) |=> (d_state[g] == D3_HOT);
    endproperty
    a_d3hot_exit: assert property (p_d3hot_exit) else $error("illegal exit from d3hot");
  end

endmodule // link_l1_substate_power_control
`default_nettype wire

// ---- verification/platform_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module platform_model #(parameter int LOCK_CYC = 4, parameter int HOLD_CYC = 8) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pll_pd,
  input wire logic perst_hold,
  output logic perst_n,
  output logic pll_lock
);
  int lock_cnt;
  int hold_cnt;
  // slow relock, so a resume that ignores lock shows up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= 0;
      hold_cnt <= 0;
    end else begin
      lock_cnt <= pll_pd ? 0 : (lock_cnt < LOCK_CYC ? lock_cnt + 1 : lock_cnt);
      hold_cnt <= perst_hold ? 0 : (hold_cnt < HOLD_CYC ? hold_cnt + 1 : hold_cnt);
    end
  end
  assign pll_lock = (lock_cnt == LOCK_CYC);
  assign perst_n = (hold_cnt == HOLD_CYC);
endmodule // platform_model
`default_nettype wire

// ---- verification/test_link_l1_substate_power_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "l1ss_regs.svh"
module test_link_l1_substate_power_control;
  import l1ss_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic perst_hold = 1'b1;
  logic perst_n, pll_lock, func_rst_n, pll_pd;
  logic [2:0] clkreq_n = 3'h7;
  logic [2:0] l11_allow = 3'h7;
  logic [2:0] rx_buf_pd, l11_active, link_resume;
  link_req_e [2:0] link_req = '{default: REQ_NONE};
  d_state_e [2:0] d_req = '{default: D0};
  link_state_e [2:0] link_state;
  d_state_e [2:0] d_state;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  link_l1_substate_power_control u_link_l1_substate_power_control (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .perst_n(perst_n), .clkreq_n(clkreq_n), .l11_allow(l11_allow),
    .pll_lock(pll_lock), .link_req(link_req), .d_req(d_req), .func_rst_n(func_rst_n),
    .pll_pd(pll_pd), .rx_buf_pd(rx_buf_pd), .l11_active(l11_active),
    .link_resume(link_resume), .link_state(link_state), .d_state(d_state));
  platform_model u_platform_model (.clk(clk), .rst_n(rst_n), .pll_pd(pll_pd),
    .perst_hold(perst_hold), .perst_n(perst_n), .pll_lock(pll_lock));
  // ----------------------------------------
  // checks and helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_hi;
    for (int i = 0; i < 30 && link_resume !== 3'h7; i++) step(1);
  endtask
  task automatic go(input link_req_e r, input link_state_e e);
    link_req = '{default: r};
    step(1);
    chk(link_state, {3{e}});
  endtask
  task automatic go_d(input d_state_e r, input d_state_e e);
    d_req = '{default: r};
    step(1);
    chk(d_state, {3{e}});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_l11;
    clkreq_n = 3'h6;
    step(1);
    chk(l11_active, 3'h1);
    chk({rx_buf_pd, link_resume}, 6'h0e);
    chk(pll_pd, 1'b0);
    clkreq_n = 3'h0;
    step(1);
    chk({l11_active, pll_pd}, 4'hf);
    clkreq_n = 3'h7;
    step(1);
    chk({l11_active, rx_buf_pd, pll_pd}, 7'h00);
    step(2);
    chk(link_resume, 3'h0);
    wait_hi;
    chk({pll_lock, link_resume}, 4'hf);
    $display("l11 done");
  endtask
  task automatic t_refuse;
    l11_allow = 3'h3;
    clkreq_n = 3'h0;
    step(1);
    chk({l11_active, pll_pd}, 4'h6);
    clkreq_n = 3'h7;
    step(1);
    wait_hi;
    chk(link_resume, 3'h7);
    $display("refuse done");
  endtask
  task automatic t_link;
    go(REQ_L0, LK_L0);
    go(REQ_L0S, LK_L0S);
    go(REQ_L0, LK_L0);
    go(REQ_L1, LK_L1);
    link_req = '{default: REQ_NONE};
    step(1);
    $display("link done");
  endtask
  task automatic t_deep;
    go(REQ_L0, LK_L0);
    go(REQ_L2L3, LK_L2L3);
    go(REQ_L3, LK_L3);
    go(REQ_L0, LK_L0);
    $display("deep done");
  endtask
  task automatic t_dstate;
    go_d(D1, D1);
    go_d(D2, D2);
    go_d(D1, D2);
    go_d(D3_HOT, D3_HOT);
    go_d(D0, D0);
    $display("dstate done");
  endtask
  // clock enable low must freeze a legal request
  task automatic t_freeze;
    clk_en = 1'b0;
    link_req = '{default: REQ_L0S};
    step(2);
    chk(link_state, {3{LK_L0}});
    clk_en = 1'b1;
    step(1);
    chk(link_state, {3{LK_L0S}});
    $display("freeze done");
  endtask
  task automatic t_perst;
    perst_hold = 1'b1;
    step(3);
    chk({func_rst_n, d_state}, {1'b0, {3{D3_COLD}}});
    chk(link_state, {3{LK_L3}});
    chk(link_resume, 3'h0);
    perst_hold = 1'b0;
    for (int i = 0; i < 30 && func_rst_n !== 1'b1; i++) step(1);
    chk({func_rst_n, d_state}, {1'b1, {3{D0}}});
    chk(link_resume, 3'h7);
    $display("perst done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      report_and_stop;
    end
  end
  initial begin
    step(6);
    rst_n = 1'b1;
    step(1);
    t_perst;
    t_link;
    t_l11;
    t_refuse;
    t_deep;
    t_dstate;
    t_freeze;
    t_perst;
    report_and_stop;
  end
endmodule // test_link_l1_substate_power_control
`default_nettype wire
